/* design/sbl_pkg.sv */
// constants for the serial boot-entry and image-upload host controller
package sbl_pkg;
  // clock and serial timing
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD = 115200;
  localparam int BIT_CYCLES = CLK_HZ / BAUD;
  localparam int HALF_BIT = BIT_CYCLES / 2;
  localparam int FRAME_BITS = 10;
  // break is held for twice a frame so it cannot pass for a character
  localparam int BREAK_BITS = 2 * FRAME_BITS;
  localparam int BREAK_CYCLES = BREAK_BITS * BIT_CYCLES;
  localparam int RESET_US = 1000;
  localparam int RESET_CYCLES = (CLK_HZ / 1_000_000) * RESET_US;
  localparam int RESP_MS = 2000;
  localparam int RESP_CYCLES = (CLK_HZ / 1000) * RESP_MS;
  localparam int FIFO_DEPTH = 16;
  // characters
  localparam logic [7:0] CHR_CR = 8'h0d;
  localparam logic [7:0] CHR_ONE = 8'h31;
  localparam logic [7:0] CHR_TWO = 8'h32;
  localparam logic [7:0] CHR_CRC_REQ = 8'h43;
  localparam logic [7:0] CHR_DONE = 8'h63;
  localparam logic [7:0] CHR_ABORT = 8'h61;
  localparam logic [31:0] LOADER_PROMPT = 32'h424c203e;
  // xmodem framing
  localparam logic [7:0] XM_SOH = 8'h01;
  localparam logic [7:0] XM_EOT = 8'h04;
  localparam logic [7:0] XM_ACK = 8'h06;
  localparam logic [7:0] XM_NAK = 8'h15;
  localparam logic [7:0] XM_CAN = 8'h18;
  localparam logic [7:0] XM_PAD = 8'h1a;
  localparam logic [7:0] BLOCK_BYTES = 8'h80;
  localparam logic [7:0] IDX_CRC_HI = 8'h83;
  localparam logic [7:0] IDX_LAST = 8'h84;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  // sequencer states, gray along the usual path
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_ENTRY = 4'h1, S_BOOT = 4'h3, S_CR = 4'h2,
    S_PROMPT = 4'h6, S_ONE = 4'h7, S_WAIT_C = 4'h5, S_FILL = 4'h4,
    S_SEND = 4'hc, S_ACKW = 4'hd, S_EOT = 4'hf, S_EOTW = 4'he,
    S_RESULT = 4'ha, S_TWO = 4'hb, S_DONE = 4'h9, S_FAIL = 4'h8
  } sbl_state_t;
endpackage

/* design/sbl_fifo.sv */
// first-in first-out buffer with valid/ready on both sides
module sbl_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // fill side
  input wire logic [WIDTH-1:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  // drain side
  output logic [WIDTH-1:0] o_data,
  output logic o_valid,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  logic push;
  logic pop;

  // extra pointer bit tells full from empty
  assign o_ready = (wptr[AW] == rptr[AW]) || (wptr[AW-1:0] != rptr[AW-1:0]);
  assign o_valid = wptr != rptr;
  assign o_data = mem[rptr[AW-1:0]];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  // storage
  always_ff @(posedge i_clock)
  begin
    if (push)
      mem[wptr[AW-1:0]] <= i_data;
  end

  // pointers
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      wptr <= '0;
      rptr <= '0;
    end
    else
    begin
      if (push)
        wptr <= wptr + 1'h1;
      if (pop)
        rptr <= rptr + 1'h1;
    end
  end
endmodule

/* design/sbl_host.sv */
// host controller: forces the module's serial loader and uploads an image by xmodem-crc
// Behaviour
// (RQ1) hold sleep request low and rts high before resetting the module; the code drops sleep request in the same cycle as reset
// (RQ2) keep a serial break on the module input across its reset
// (RQ3) while the module leaves reset keep sleep request and serial input low
// (RQ4) after power-up end the break and send one carriage return at 115200
// (RQ5) module answers a good entry with its menu text at 115200
// (RQ6) no hardware flow control during entry or menu exchange
// (RQ7) every character is 8 data bits, no parity, one stop bit
// (RQ8) module without a valid image always starts in its loader
// (RQ9) an explicit application call into the loader never returns
// (RQ10) menu may run on uart or spi; spi clock comes from the master
// (RQ11) see the loader prompt before sending any menu choice
// (RQ12) ascii one at the menu starts an update awaiting an upload
// (RQ13) image goes by xmodem crc mode, blocks strictly in order
// (RQ14) good load gives a completion string; ascii two then starts firmware
// (RQ15) failed load gives an abort string and returns to the menu
// (RQ16) module aborts if no first block within one minute
// (RQ17) reset or power loss during loading fails the load
// (RQ18) file or flash error during loading aborts the update
// (RQ19) break lasts longer than one full character frame
// (RQ20) block is start, number, complement, 128 bytes, crc16; ack or nak
module sbl_host
  import sbl_pkg::*;
#(
  parameter int RESET_CYC = sbl_pkg::RESET_CYCLES,
  parameter int BREAK_CYC = sbl_pkg::BREAK_CYCLES,
  parameter int RESP_CYC = sbl_pkg::RESP_CYCLES,
  // bit time in clocks; the default gives 115200 baud at the package clock
  parameter int BIT_CYC = sbl_pkg::BIT_CYCLES
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // user control
  input wire logic i_start,
  output logic o_busy,
  output logic o_done,
  output logic o_fail,
  // image byte stream
  input wire logic [7:0] i_img_data,
  input wire logic i_img_last,
  input wire logic i_img_valid,
  output logic o_img_ready,
  // module pins
  output logic o_txd,
  input wire logic i_rxd,
  output logic o_rts,
  output logic o_sleep_request_pin,
  output logic o_module_reset_n
);
  import sbl_pkg::*;

  sbl_state_t state;
  sbl_state_t next_state;
  logic [31:0] tick;
  logic brk;
  logic [7:0] mem [128];
  logic [7:0] fidx;
  logic [7:0] sidx;
  logic [7:0] blk;
  logic [15:0] crc;
  logic ended;
  logic ok_seen;
  logic [1:0] pm;
  logic prompt_hit;
  logic timeout;
  logic [8:0] fifo_data;
  logic fifo_valid;
  logic fifo_ready;
  logic tx_go;
  logic [7:0] tx_data;
  logic tx_busy;
  logic [9:0] tx_shift;
  logic [15:0] tx_cnt;
  logic [3:0] tx_bits;
  logic rx_s1;
  logic rx_s2;
  logic rx_busy;
  logic [15:0] rx_cnt;
  logic [3:0] rx_bits;
  logic [7:0] rx_byte;
  logic rx_valid;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++)
      r = r[15] ? ({r[14:0], 1'h0} ^ CRC_POLY) : {r[14:0], 1'h0};
    return r;
  endfunction

  // image bytes queue here; back-pressure reaches the user through o_img_ready
  sbl_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_data({i_img_last, i_img_data}),
    .i_valid(i_img_valid),
    .o_ready(o_img_ready),
    .o_data(fifo_data),
    .o_valid(fifo_valid),
    .i_ready(fifo_ready)
  );

  assign brk = (state == S_ENTRY) || (state == S_BOOT);
  assign fifo_ready = (state == S_FILL) && (fidx != BLOCK_BYTES) && !ended;
  assign prompt_hit = rx_valid && (pm == 2'h3) && (rx_byte == LOADER_PROMPT[7:0]); // RQ11
  assign timeout = tick == 32'(RESP_CYC - 1);
  assign o_busy = (state != S_IDLE) && (state != S_DONE) && (state != S_FAIL);
  assign o_done = state == S_DONE;
  assign o_fail = state == S_FAIL;

  // character to launch; block layout is start, number, complement, data, crc
  always_comb
  begin
    case (state)
      S_CR: tx_data = CHR_CR; // RQ4
      S_ONE: tx_data = CHR_ONE; // RQ12
      S_TWO: tx_data = CHR_TWO; // RQ14
      S_EOT: tx_data = XM_EOT;
      S_SEND:
        if (sidx == 8'h00)
          tx_data = XM_SOH; // RQ20
        else if (sidx == 8'h01)
          tx_data = blk; // RQ13
        else if (sidx == 8'h02)
          tx_data = ~blk;
        else if (sidx == IDX_CRC_HI)
          tx_data = crc[15:8];
        else if (sidx == IDX_LAST)
          tx_data = crc[7:0];
        else
          tx_data = mem[7'(sidx - 8'h03)];
      default: tx_data = 8'h00;
    endcase
  end
  assign tx_go = !tx_busy && ((state == S_CR) || (state == S_ONE) || (state == S_TWO)
    || (state == S_EOT) || (state == S_SEND));

  // sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      S_IDLE, S_DONE, S_FAIL:
        if (i_start)
          next_state = S_ENTRY;
      S_ENTRY:
        if (tick == 32'(RESET_CYC - 1))
          next_state = S_BOOT; // RQ2
      S_BOOT:
        if (tick == 32'(BREAK_CYC - 1))
          next_state = S_CR; // RQ19
      S_CR:
        if (tx_go)
          next_state = S_PROMPT;
      S_PROMPT:
        if (prompt_hit)
          next_state = S_ONE; // RQ11
        else if (timeout)
          next_state = S_FAIL;
      S_ONE:
        if (tx_go)
          next_state = S_WAIT_C;
      S_WAIT_C:
        if (rx_valid && rx_byte == CHR_CRC_REQ)
          next_state = S_FILL; // RQ13
        else if (timeout)
          next_state = S_FAIL;
      S_FILL:
        if (fidx == BLOCK_BYTES)
          next_state = S_SEND;
      S_SEND:
        if (tx_go && sidx == IDX_LAST)
          next_state = S_ACKW;
      S_ACKW:
        if (rx_valid && rx_byte == XM_ACK)
          next_state = ended ? S_EOT : S_FILL; // RQ20
        else if (rx_valid && rx_byte == XM_NAK)
          next_state = S_SEND;
        else if ((rx_valid && rx_byte == XM_CAN) || timeout)
          next_state = S_FAIL;
      S_EOT:
        if (tx_go)
          next_state = S_EOTW;
      S_EOTW:
        if (rx_valid && rx_byte == XM_ACK)
          next_state = S_RESULT;
        else if (rx_valid && rx_byte == XM_NAK)
          next_state = S_EOT;
        else if (timeout)
          next_state = S_FAIL;
      S_RESULT:
        if (prompt_hit)
          next_state = ok_seen ? S_TWO : S_FAIL; // RQ14
        else if (timeout)
          next_state = S_FAIL;
      S_TWO:
        if (tx_go)
          next_state = S_DONE;
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
      state <= S_IDLE;
    else
      state <= next_state;
  end

  // shared wait counter, restarted by a state change or any received byte
  always_ff @(posedge i_clock)
  begin
    if (i_reset || next_state != state || rx_valid)
      tick <= '0;
    else
      tick <= tick + 32'h1;
  end

  // pins: no flow control, rts simply held high
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      o_rts <= 1'h1;
      o_sleep_request_pin <= 1'h1;
      o_module_reset_n <= 1'h1;
      o_txd <= 1'h1;
    end
    else
    begin
      o_rts <= 1'h1; // RQ6
      o_sleep_request_pin <= !brk; // RQ1 RQ3
      o_module_reset_n <= state != S_ENTRY;
      o_txd <= !brk && (tx_busy ? tx_shift[0] : 1'h1); // RQ3
    end
  end

  // block assembly; the short last block is padded, the copy serves resends
  always_ff @(posedge i_clock)
  begin
    if (i_reset || state == S_WAIT_C)
    begin
      fidx <= '0;
      crc <= '0;
      blk <= 8'h01;
      ended <= 1'h0;
    end
    else if (state == S_ACKW && rx_valid && rx_byte == XM_ACK)
    begin
      fidx <= '0;
      crc <= '0;
      blk <= blk + 8'h01; // RQ13
    end
    else if (state == S_FILL && fidx != BLOCK_BYTES && (ended || fifo_valid))
    begin
      mem[7'(fidx)] <= ended ? XM_PAD : fifo_data[7:0];
      crc <= crc_step(crc, ended ? XM_PAD : fifo_data[7:0]); // RQ20
      fidx <= fidx + 8'h01;
      if (!ended && fifo_data[8])
        ended <= 1'h1;
    end
  end

  // byte position within the outgoing block
  always_ff @(posedge i_clock)
  begin
    if (i_reset || state != S_SEND)
      sidx <= '0;
    else if (tx_go)
      sidx <= sidx + 8'h01;
  end

  // completion versus abort text, judged by its first letter
  always_ff @(posedge i_clock)
  begin
    if (i_reset || state == S_EOTW)
      ok_seen <= 1'h0;
    else if (state == S_RESULT && rx_valid && rx_byte == CHR_DONE)
      ok_seen <= 1'h1;
    else if (state == S_RESULT && rx_valid && rx_byte == CHR_ABORT)
      ok_seen <= 1'h0;
  end

  // prompt matcher; a mismatch restarts unless it is itself the first letter
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
      pm <= '0;
    else if (rx_valid)
    begin
      if (rx_byte == LOADER_PROMPT[31 - 8 * pm -: 8])
        pm <= pm + 2'h1;
      else
        pm <= (rx_byte == LOADER_PROMPT[31:24]) ? 2'h1 : 2'h0;
    end
  end

  // transmitter, 8n1: start, eight data lsb first, stop
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      tx_busy <= 1'h0;
      tx_shift <= '1;
      tx_cnt <= '0;
      tx_bits <= '0;
    end
    else if (tx_go)
    begin
      tx_busy <= 1'h1;
      tx_shift <= {1'h1, tx_data, 1'h0}; // RQ7
      tx_cnt <= 16'(BIT_CYC - 1); // RQ4 RQ10
      tx_bits <= '0;
    end
    else if (tx_busy)
    begin
      if (tx_cnt != 16'h0)
        tx_cnt <= tx_cnt - 16'h1;
      else if (tx_bits == 4'(FRAME_BITS - 1))
        tx_busy <= 1'h0;
      else
      begin
        tx_cnt <= 16'(BIT_CYC - 1);
        tx_bits <= tx_bits + 4'h1;
        tx_shift <= {1'h1, tx_shift[9:1]};
      end
    end
  end

  // serial input synchroniser
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      rx_s1 <= 1'h1;
      rx_s2 <= 1'h1;
    end
    else
    begin
      rx_s1 <= i_rxd;
      rx_s2 <= rx_s1;
    end
  end

  // receiver samples mid-bit; a frame with a low stop bit is dropped
  always_ff @(posedge i_clock)
  begin
    rx_valid <= 1'h0;
    if (i_reset)
    begin
      rx_busy <= 1'h0;
      rx_cnt <= '0;
      rx_bits <= '0;
      rx_byte <= '0;
    end
    else if (!rx_busy)
    begin
      if (!rx_s2)
      begin
        rx_busy <= 1'h1;
        rx_cnt <= 16'(BIT_CYC / 2 - 1);
        rx_bits <= '0;
      end
    end
    else if (rx_cnt != 16'h0)
      rx_cnt <= rx_cnt - 16'h1;
    else
    begin
      rx_cnt <= 16'(BIT_CYC - 1);
      rx_bits <= rx_bits + 4'h1;
      if (rx_bits == 4'h0 && rx_s2)
        rx_busy <= 1'h0;
      else if (rx_bits == 4'(FRAME_BITS - 1))
      begin
        rx_busy <= 1'h0;
        rx_valid <= rx_s2; // RQ7
      end
      else if (rx_bits != 4'h0)
        rx_byte <= {rx_s2, rx_byte[7:1]};
    end
  end

  property p_entry_pins;
    @(posedge i_clock) disable iff (i_reset)
    !o_module_reset_n |-> (!o_sleep_request_pin && o_rts);
  endproperty
  a_entry_pins: assert property (p_entry_pins) else $error("entry pins wrong in reset"); // RQ1

  property p_break_reset;
    @(posedge i_clock) disable iff (i_reset)
    $fell(o_module_reset_n) |-> !o_txd;
  endproperty
  a_break_reset: assert property (p_break_reset) else $error("no break at module reset"); // RQ2

  property p_boot_low;
    @(posedge i_clock) disable iff (i_reset)
    $rose(o_module_reset_n) |-> (!o_txd && !o_sleep_request_pin && o_rts)[*8];
  endproperty
  a_boot_low: assert property (p_boot_low) else $error("pins not held at reset release"); // RQ3

  property p_cr_after;
    @(posedge i_clock) disable iff (i_reset)
    // a user reset also ends the break, but no character follows that one
    ($fell(brk) && !$past(i_reset)) |-> (tx_go && tx_data == CHR_CR);
  endproperty
  a_cr_after: assert property (p_cr_after) else $error("no carriage return after break"); // RQ4

  property p_frame;
    @(posedge i_clock) disable iff (i_reset)
    (tx_go && !brk) |=> ##1 !o_txd[*8];
  endproperty
  a_frame: assert property (p_frame) else $error("start bit missing"); // RQ7

  property p_prompt_first;
    @(posedge i_clock) disable iff (i_reset)
    $rose(state == S_ONE) |-> $past(prompt_hit);
  endproperty
  a_prompt_first: assert property (p_prompt_first) else $error("menu choice before prompt"); // RQ11

  property p_one;
    @(posedge i_clock) disable iff (i_reset)
    (tx_go && state == S_ONE) |=> (state == S_WAIT_C && tx_shift[8:1] == CHR_ONE);
  endproperty
  a_one: assert property (p_one) else $error("update not started by ascii one"); // RQ12

  property p_order;
    @(posedge i_clock) disable iff (i_reset)
    (tx_go && sidx == 8'h02) |-> (tx_data == ~blk && $past(tx_busy));
  endproperty
  a_order: assert property (p_order) else $error("block number complement wrong"); // RQ13

  property p_two;
    @(posedge i_clock) disable iff (i_reset)
    (tx_go && tx_data == CHR_TWO && state == S_TWO) |-> ok_seen;
  endproperty
  a_two: assert property (p_two) else $error("ascii two without completion"); // RQ14

  property p_crc;
    @(posedge i_clock) disable iff (i_reset)
    (tx_go && sidx == IDX_CRC_HI) |-> (tx_data == crc[15:8] && fidx == BLOCK_BYTES);
  endproperty
  a_crc: assert property (p_crc) else $error("crc byte wrong"); // RQ20
endmodule

/* tb/sbl_dev_model.sv */
// behavioural model of the radio module's serial loader, seen from its pins
module sbl_dev_model
  import sbl_pkg::*;
#(
  parameter int IMG_LEN = 20,
  parameter int BIT_CYC = BIT_CYCLES
) (
  // clock
  input wire logic i_clock,
  // pins driven by the host
  input wire logic i_rxd,
  input wire logic i_rts,
  input wire logic i_sleep_request_pin,
  input wire logic i_module_reset_n,
  // pin toward the host and bench hooks
  output logic o_txd,
  input wire logic [1:0] i_mode,
  output logic [7:0] o_errors
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx;
  logic [15:0] crc;
  int n;
  initial o_txd = 1'b1;
  initial o_errors = 8'h00;
  // count and report a wrong value seen on the host's pins
  task automatic want(input logic [15:0] got, input logic [15:0] exp);
    if (got !== exp)
    begin
      o_errors = o_errors + 8'h01;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic clk(input int c);
    repeat (c) @(posedge i_clock);
  endtask
  function automatic logic [7:0] img(input int k);
    return (k < IMG_LEN) ? 8'ha0 + k[7:0] : XM_PAD;
  endfunction
  // uart only: mid-bit sampling, lsb first, no spi path
  task automatic get(output logic [7:0] b);
    @(posedge i_clock iff i_rxd === 1'b0);
    clk(BIT_CYC / 2);
    for (int i = 0; i < 8; i++)
    begin
      clk(BIT_CYC);
      b[i] = i_rxd;
    end
    clk(BIT_CYC);
    want(i_rxd, 1'b1);
    want(i_rts, 1'b1);
  endtask
  // the last byte of a burst gets a short stop so we listen again in time
  task automatic put(input logic [7:0] b, input bit more);
    o_txd <= 1'b0;
    clk(BIT_CYC);
    for (int i = 0; i < 8; i++)
    begin
      o_txd <= b[i];
      clk(BIT_CYC);
    end
    o_txd <= 1'b1;
    clk(more ? BIT_CYC : BIT_CYC / 4);
  endtask
  task automatic prompt();
    for (int k = 3; k >= 0; k--)
      put(LOADER_PROMPT[k*8 +: 8], k != 0);
  endtask
  // one block: start, number, complement, data, crc high then low
  task automatic block();
    get(rx);
    want(rx, XM_SOH);
    get(rx);
    want(rx, 8'h01);
    get(rx);
    want(rx, 8'hfe);
    crc = 16'h0000;
    for (int k = 0; k < 128; k++)
    begin
      get(rx);
      want(rx, img(k));
      crc = crc ^ {rx, 8'h00};
      for (int j = 0; j < 8; j++)
        crc = crc[15] ? ((crc << 1) ^ CRC_POLY) : (crc << 1);
    end
    get(rx);
    want(rx, crc[15:8]);
    get(rx);
    want(rx, crc[7:0]);
  endtask
  // every forced entry lands in the loader; no way back to an application
  initial
  forever
  begin
    @(negedge i_module_reset_n);
    // let the pins that moved on the same edge settle before looking
    @(negedge i_clock);
    want({i_sleep_request_pin, i_rxd, i_rts}, 3'b001);
    @(posedge i_module_reset_n);
    @(negedge i_clock);
    want({i_sleep_request_pin, i_rxd, i_rts}, 3'b001);
    n = 0;
    while (i_rxd !== 1'b1)
    begin
      clk(1);
      n++;
    end
    want(n > FRAME_BITS * BIT_CYC, 1'b1);
    get(rx);
    want(rx, CHR_CR);
    prompt();
    get(rx);
    want(rx, CHR_ONE);
    // mode 3 stays silent so the host has to give up on its own
    if (i_mode != 2'd3)
    begin
      put(CHR_CRC_REQ, 1'b0);
      block();
      if (i_mode == 2'd2)
      begin
        put(XM_NAK, 1'b0);
        block();
        put(XM_CAN, 1'b0);
      end
      else
      begin
        put(XM_ACK, 1'b0);
        get(rx);
        want(rx, XM_EOT);
        put(XM_ACK, 1'b1);
        put((i_mode == 2'd0) ? CHR_DONE : CHR_ABORT, 1'b1);
        prompt();
        if (i_mode == 2'd0)
        begin
          get(rx);
          want(rx, CHR_TWO);
        end
      end
    end
  end
endmodule

/* tb/tb.sv */
// self-checking bench: host controller against the module loader model
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sbl_pkg::*;
  localparam int IMG_LEN = 20;
  // short bit time keeps four loader runs within some tens of thousands of cycles
  localparam int BIT_CYC = 8;
  typedef struct packed {logic [1:0] mode; logic done; logic fail;} sbl_row_t;
  // success, abort text, nak then cancel, silent loader
  sbl_row_t rows [4] = '{'{2'd0, 1'b1, 1'b0}, '{2'd1, 1'b0, 1'b1},
    '{2'd2, 1'b0, 1'b1}, '{2'd3, 1'b0, 1'b1}};
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic i_start = 1'b0;
  logic [7:0] i_img_data = 8'h00;
  logic i_img_last = 1'b0;
  logic i_img_valid = 1'b0;
  logic o_busy, o_done, o_fail, o_img_ready, o_txd, i_rxd, o_rts;
  logic o_sleep_request_pin, o_module_reset_n;
  logic [1:0] dev_mode = 2'd0;
  logic [7:0] dev_err;
  int compares = 0;
  int miscompares = 0;
  int n;
  // break of 100 clocks still outlasts a frame of ten bit times
  sbl_host #(.RESET_CYC(20), .BREAK_CYC(100), .RESP_CYC(2000), .BIT_CYC(BIT_CYC)) uut (
    .i_clock(i_clock), .i_reset(i_reset), .i_start(i_start), .o_busy(o_busy),
    .o_done(o_done), .o_fail(o_fail), .i_img_data(i_img_data),
    .i_img_last(i_img_last), .i_img_valid(i_img_valid), .o_img_ready(o_img_ready),
    .o_txd(o_txd), .i_rxd(i_rxd), .o_rts(o_rts),
    .o_sleep_request_pin(o_sleep_request_pin), .o_module_reset_n(o_module_reset_n));
  sbl_dev_model #(.IMG_LEN(IMG_LEN), .BIT_CYC(BIT_CYC)) dev (
    .i_clock(i_clock), .i_rxd(o_txd), .i_rts(o_rts),
    .i_sleep_request_pin(o_sleep_request_pin), .i_module_reset_n(o_module_reset_n),
    .o_txd(i_rxd), .i_mode(dev_mode), .o_errors(dev_err));
  // free-running 100 mhz clock
  initial
  begin
    forever #5 i_clock = ~i_clock;
  end
  function automatic logic [7:0] img(input int k);
    return 8'ha0 + k[7:0];
  endfunction
  // offer bytes one by one; a byte goes in at the edge after ready is seen
  task automatic feed(input int from, input int upto);
    for (int k = from; k < upto; k++)
    begin
      i_img_data <= img(k);
      i_img_last <= (k == IMG_LEN - 1);
      i_img_valid <= 1'b1;
      @(negedge i_clock);
      while (o_img_ready !== 1'b1)
        @(negedge i_clock);
      @(posedge i_clock);
    end
    i_img_valid <= 1'b0;
  endtask
  task automatic idle_check();
    @(negedge i_clock);
    `CHK({o_txd, o_rts, o_sleep_request_pin, o_module_reset_n, o_busy, o_done, o_fail,
      o_img_ready}, 8'hf1)
  endtask
  task automatic summarize();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog sized for four loader runs of up to two blocks each
  initial
  begin
    repeat (90_000) @(posedge i_clock);
    miscompares++;
    summarize();
  end
  initial
  begin
    repeat (4) @(posedge i_clock);
    i_reset <= 1'b0;
    idle_check();
    @(posedge i_clock);
    foreach (rows[r])
    begin
      dev_mode <= rows[r].mode;
      i_start <= 1'b1;
      @(posedge i_clock);
      i_start <= 1'b0;
      @(negedge i_clock);
      `CHK(o_busy, 1'b1)
      @(posedge i_clock);
      // the host is still in its entry phase, so sixteen bytes fill the buffer
      feed(0, 16);
      @(negedge i_clock);
      `CHK(o_img_ready, 1'b0)
      @(posedge i_clock);
      if (rows[r].mode != 2'd3)
        feed(16, IMG_LEN);
      n = 0;
      while (o_done !== 1'b1 && o_fail !== 1'b1 && n < 40_000)
      begin
        @(negedge i_clock);
        n++;
      end
      `CHK(o_done, rows[r].done)
      `CHK(o_fail, rows[r].fail)
      // done rises as the final character leaves; let it and the model finish
      repeat (2 * FRAME_BITS * BIT_CYC) @(negedge i_clock);
      `CHK(dev_err, 8'h00)
      $display("test row %0d ended", r);
      @(posedge i_clock);
    end
    // reset in mid-entry: pins back to idle, leftover bytes dropped
    i_start <= 1'b1;
    @(posedge i_clock);
    i_start <= 1'b0;
    repeat (100) @(posedge i_clock);
    @(negedge i_clock);
    `CHK({o_txd, o_sleep_request_pin, o_rts, o_module_reset_n}, 4'h3)
    @(posedge i_clock);
    i_reset <= 1'b1;
    @(posedge i_clock);
    i_reset <= 1'b0;
    idle_check();
    $display("test reset ended");
    summarize();
  end
endmodule
